/* File: hdl/link_cfg_defines.svh */
// Constants of the serial link subclass and configuration block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LINK_CFG_DEFINES_SVH
`define LINK_CFG_DEFINES_SVH

// Subclass codes
`define LC_SUBCLASS_0      3'h0
`define LC_SUBCLASS_1      3'h1
`define LC_SUBCLASS_2      3'h2

// Number of lanes held by the capture store
`define LC_LANES           8

// Datapath width in bits and core clock divide ratio per line coding
`define LC_DP_BITS_66      7'h40
`define LC_DP_BITS_10      7'h20
`define LC_RATIO_66        7'h42
`define LC_RATIO_10        7'h28

// Line rate limits in Mb/s
`define LC_RATE_MIN        16'h03e8
`define LC_RATE_MAX_66     16'h7d00
`define LC_RATE_MAX_10     16'h3ff7

// Reset values of the programmed configuration
`define LC_RST_CODING      1'b0
`define LC_RST_SUBCLASS    3'h1
`define LC_RST_OCTETS_M1   8'h00
`define LC_RST_FRAMES_M1   5'h1f
`define LC_RST_LANES_M1    5'h00
`define LC_RST_SCRAMBLE    1'b0
`define LC_RST_META        2'h0
`define LC_RST_MB_M1       5'h00
`define LC_RST_SYSREF_ALL  1'b0
`define LC_RST_RATE        16'h3e80

// Octets carried per core clock in the 32-bit datapath (as a shift)
`define LC_OCT_SHIFT       2
// Blocks per multiblock in the 64-bit datapath, minus one
`define LC_BLOCKS_M1       5'h1f

`endif

/* File: hdl/link_cfg_pkg.sv */
// Types shared by the serial link subclass and configuration block.
// Assumes the constants header is on the include path.
`include "link_cfg_defines.svh"

package link_cfg_pkg;

   // Programmed link configuration
   typedef struct packed {
      logic        coding_8b10b;   // 1 = 8B10B, 0 = 64B66B
      logic [2:0]  subclass;       // Subclass code
      logic [7:0]  octets_m1;      // Octets per frame minus one
      logic [4:0]  frames_m1;      // Frames per multiframe minus one
      logic [4:0]  lanes_m1;       // Lanes per link minus one
      logic        scramble;       // Scrambling on
      logic [1:0]  meta_mode;      // Meta data mode
      logic [4:0]  mb_m1;          // Multiblocks per extended multiblock minus one
      logic        sysref_all;     // Realign on every SYSREF edge
      logic [15:0] rate_mbps;      // Line rate in Mb/s
   } cfg_s;

   // Lane alignment configuration content
   typedef struct packed {
      logic [2:0]  subclass;       // Subclass code
      logic [4:0]  lanes_m1;       // Lanes per link minus one
      logic [4:0]  lane_id;        // Lane identity
      logic        scramble;       // Scrambling on
      logic [4:0]  frames_m1;      // Frames per multiframe minus one
      logic [7:0]  octets_m1;      // Octets per frame minus one, low byte
   } ila_s;

   // Link logic states
   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_WAIT,
      LINK_RUN
   } link_state_e;

endpackage

/* File: hdl/edge_catch.sv */
// Rising edge catcher for a timing input such as SYSREF or SYNC.
// Assumes the input is synchronous to core_clk; restart clears history.
`timescale 1ns/1ps
`include "link_cfg_defines.svh"

module edge_catch (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // Control
   input  wire logic restart,
   input  wire logic enable,
   // Timing input and caught edge
   input  wire logic level_in,
   output logic      edge_pulse
);

   logic prev;        // Level seen last cycle
   logic next_prev;   // Next history value
   logic next_edge;   // Next edge pulse

   // Edge found only while enabled; history still tracks the input while disabled
   always_comb begin
      next_prev = restart ? 1'b0 : level_in;
      next_edge = enable & ~restart & level_in & ~prev;
   end

   // Register history and pulse
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prev       <= 1'b0;
         edge_pulse <= 1'b0;
      end else begin
         prev       <= next_prev;
         edge_pulse <= next_edge;
      end
   end

endmodule // edge_catch

/* File: hdl/ila_store.sv */
// Per lane store of received lane alignment configuration content.
// Assumes one capture strobe per lane, synchronous to core_clk.
`timescale 1ns/1ps
`include "link_cfg_defines.svh"

module ila_store (
   // Clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       reset_n,
   input  wire logic                       restart,
   // Capture side
   input  wire logic [`LC_LANES-1:0]       cap_valid,
   input  wire link_cfg_pkg::ila_s         cap_data,
   // Read side
   input  wire logic [2:0]                 rd_lane,
   output link_cfg_pkg::ila_s              rd_data,
   output logic [`LC_LANES-1:0]            seen
);

   link_cfg_pkg::ila_s             store [`LC_LANES];       // Per lane content
   link_cfg_pkg::ila_s             next_store [`LC_LANES];  // Next content
   logic [`LC_LANES-1:0]           next_seen;               // Next seen flags
   link_cfg_pkg::ila_s             next_rd;                 // Next read data

   // One capture slot per lane; restart forgets the seen flags only
   for (genvar g = 0; g < `LC_LANES; g++) begin : g_lane
      always_comb begin
         next_store[g] = cap_valid[g] ? cap_data : store[g];
         next_seen[g]  = cap_valid[g] | (seen[g] & ~restart);
      end
      always_ff @(posedge core_clk or negedge reset_n) begin
         if (!reset_n) begin
            store[g] <= '0;
            seen[g]  <= 1'b0;
         end else begin
            store[g] <= next_store[g];
            seen[g]  <= next_seen[g];
         end
      end
   end

   // Registered read port
   always_comb begin
      next_rd = store[rd_lane];
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= next_rd;
      end
   end

endmodule // ila_store

/* File: hdl/serial_link_subclass_config.sv */
// Subclass selection, link parameter handling and multiframe timing
// of a serial converter link layer, plus lane alignment content.
// Assumes all inputs synchronous to core_clk, the line rate divided by clk_ratio.
//
// How it works
// - 64B66B offers subclass 0,1; 8B10B adds 2
// - Subclass comes from a programmed setting
// - Reset default is subclass 1
// - SYSREF used in subclass 1, ignored otherwise
// - One-shot, periodic, gapped SYSREF all work
// - Subclass 0 has no SYSREF alignment
// - Subclass 2 aligns from SYNC only
// - Receiver launches SYNC, transmitter captures it
// - 64B66B link parameters must match converter
// - 8B10B link parameters must match converter
// - Transmitted alignment content comes from programming
// - Received alignment content stored per lane, readable
// - New settings apply only after core reset
// - 64B66B uses 64 bits at rate/66
// - 8B10B uses 32 bits at rate/40
// - Streams run on the core clock
// - 64B66B line rate 1 to 32 Gb/s
// - Octets per frame stored minus one, bits 7:0
// - Core reset keeps programmed values
`timescale 1ns/1ps
`include "link_cfg_defines.svh"

module serial_link_subclass_config (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    reset_n,
   // Core logic restart, one cycle
   input  wire logic                    core_reset,
   // Configuration programming
   input  wire logic                    cfg_wr,
   input  wire link_cfg_pkg::cfg_s      cfg_wdata,
   output link_cfg_pkg::cfg_s           cfg_prog,
   output link_cfg_pkg::cfg_s           cfg_active,
   output logic                         cfg_reject,
   // Role: 1 = receive instance, 0 = transmit instance
   input  wire logic                    rx_role,
   // Timing signals
   input  wire logic                    sysref,
   input  wire logic                    sync_n_in,
   output logic                         sync_n_out,
   // Link status
   output logic                         link_up,
   output logic                         align_err,
   output logic [6:0]                   dp_bits,
   output logic [6:0]                   clk_ratio,
   output logic                         rate_ok,
   // Transmit lane alignment content
   output link_cfg_pkg::ila_s           ila_tx_cfg,
   // Receive lane alignment capture and read
   input  wire logic [`LC_LANES-1:0]    ila_rx_valid,
   input  wire link_cfg_pkg::ila_s      ila_rx_data,
   input  wire logic [2:0]              ila_rd_lane,
   output link_cfg_pkg::ila_s           ila_rd_data,
   output logic [`LC_LANES-1:0]         ila_seen,
   // Data stream in
   input  wire logic [63:0]             s_tdata,
   input  wire logic                    s_tvalid,
   // Data stream out
   output logic [63:0]                  m_tdata,
   output logic                         m_tvalid,
   output logic                         m_sof
);

   // ------------------------------------------------------------
   // Programmed configuration
   // ------------------------------------------------------------
   link_cfg_pkg::cfg_s next_prog;     // Next programmed value
   logic               next_reject;   // Next reject pulse
   logic               wr_legal;      // Write carries a legal subclass

   // Subclass legality depends on the coding written alongside it
   always_comb begin
      wr_legal = (cfg_wdata.subclass == `LC_SUBCLASS_0) ||
                 (cfg_wdata.subclass == `LC_SUBCLASS_1) ||
                 ((cfg_wdata.subclass == `LC_SUBCLASS_2) && cfg_wdata.coding_8b10b);
      next_prog   = cfg_prog;
      next_reject = 1'b0;
      if (cfg_wr && wr_legal) begin
         next_prog = cfg_wdata;
      end else if (cfg_wr) begin
         // Illegal write leaves all settings unchanged
         next_reject = 1'b1;
      end
   end

   // Only reset_n clears the programmed values
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_prog.coding_8b10b <= `LC_RST_CODING;
         cfg_prog.subclass     <= `LC_RST_SUBCLASS;
         cfg_prog.octets_m1    <= `LC_RST_OCTETS_M1;
         cfg_prog.frames_m1    <= `LC_RST_FRAMES_M1;
         cfg_prog.lanes_m1     <= `LC_RST_LANES_M1;
         cfg_prog.scramble     <= `LC_RST_SCRAMBLE;
         cfg_prog.meta_mode    <= `LC_RST_META;
         cfg_prog.mb_m1        <= `LC_RST_MB_M1;
         cfg_prog.sysref_all   <= `LC_RST_SYSREF_ALL;
         cfg_prog.rate_mbps    <= `LC_RST_RATE;
         cfg_reject            <= 1'b0;
      end else begin
         cfg_prog              <= next_prog;
         cfg_reject            <= next_reject;
      end
   end

   // ------------------------------------------------------------
   // Active configuration and derived link figures
   // ------------------------------------------------------------
   link_cfg_pkg::cfg_s next_act;      // Next applied configuration
   link_cfg_pkg::ila_s next_ila_tx;   // Next transmitted content
   logic [6:0]         next_dp_bits;  // Next datapath width
   logic [6:0]         next_ratio;    // Next clock ratio
   logic               next_rate_ok;  // Next rate check
   logic [15:0]        rate_max;      // Upper rate for the coding

   // Applied set changes only on a core reset
   always_comb begin
      next_act = core_reset ? cfg_prog : cfg_active;
      next_dp_bits = next_act.coding_8b10b ? `LC_DP_BITS_10 : `LC_DP_BITS_66;
      next_ratio   = next_act.coding_8b10b ? `LC_RATIO_10 : `LC_RATIO_66;
      rate_max     = next_act.coding_8b10b ? `LC_RATE_MAX_10 : `LC_RATE_MAX_66;
      next_rate_ok = (next_act.rate_mbps >= `LC_RATE_MIN) &&
                     (next_act.rate_mbps <= rate_max);
      next_ila_tx.subclass  = next_act.subclass;
      next_ila_tx.lanes_m1  = next_act.lanes_m1;
      next_ila_tx.lane_id   = 5'h00;
      next_ila_tx.scramble  = next_act.scramble;
      next_ila_tx.frames_m1 = next_act.frames_m1;
      next_ila_tx.octets_m1 = next_act.octets_m1;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_active.coding_8b10b <= `LC_RST_CODING;
         cfg_active.subclass     <= `LC_RST_SUBCLASS;
         cfg_active.octets_m1    <= `LC_RST_OCTETS_M1;
         cfg_active.frames_m1    <= `LC_RST_FRAMES_M1;
         cfg_active.lanes_m1     <= `LC_RST_LANES_M1;
         cfg_active.scramble     <= `LC_RST_SCRAMBLE;
         cfg_active.meta_mode    <= `LC_RST_META;
         cfg_active.mb_m1        <= `LC_RST_MB_M1;
         cfg_active.sysref_all   <= `LC_RST_SYSREF_ALL;
         cfg_active.rate_mbps    <= `LC_RST_RATE;
         dp_bits                 <= `LC_DP_BITS_66;
         clk_ratio               <= `LC_RATIO_66;
         rate_ok                 <= 1'b1;
         ila_tx_cfg              <= '0;
      end else begin
         cfg_active              <= next_act;
         dp_bits                 <= next_dp_bits;
         clk_ratio               <= next_ratio;
         rate_ok                 <= next_rate_ok;
         ila_tx_cfg              <= next_ila_tx;
      end
   end

   // ------------------------------------------------------------
   // Timing edge catchers
   // ------------------------------------------------------------
   logic sysref_edge;   // Caught SYSREF edge
   logic sync_edge;     // Caught SYNC release edge
   logic sysref_en;     // SYSREF watched
   logic sync_en;       // SYNC watched

   assign sysref_en = (cfg_active.subclass == `LC_SUBCLASS_1);
   assign sync_en   = (cfg_active.subclass == `LC_SUBCLASS_2) && !rx_role;

   edge_catch u_sysref_catch (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .restart    (core_reset),
      .enable     (sysref_en),
      .level_in   (sysref),
      .edge_pulse (sysref_edge)
   );

   edge_catch u_sync_catch (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .restart    (core_reset),
      .enable     (sync_en),
      .level_in   (sync_n_in),
      .edge_pulse (sync_edge)
   );

   // ------------------------------------------------------------
   // Link state, multiframe counter and SYNC launch
   // ------------------------------------------------------------
   link_cfg_pkg::link_state_e state;       // Link state
   link_cfg_pkg::link_state_e next_state;  // Next link state
   logic [11:0]  lmfc;                     // Multiframe phase count
   logic [11:0]  next_lmfc;                // Next phase count
   logic [11:0]  period_m1;                // Multiframe length minus one
   logic [14:0]  oct;                      // Octets per frame
   logic [14:0]  frm;                      // Frames per multiframe
   logic [14:0]  prod;                     // Octets per multiframe
   logic [11:0]  quarter;                  // Cycles per multiframe
   logic         wrap;                     // Last cycle of multiframe
   logic         next_sync_n;              // Next SYNC level
   logic         next_up;                  // Next link up
   logic         next_err;                 // Next alignment error
   logic         next_sof;                 // Next start marker

   // Multiframe length in core clocks for the applied coding
   always_comb begin
      oct     = 15'(cfg_active.octets_m1) + 15'h0001;
      frm     = 15'(cfg_active.frames_m1) + 15'h0001;
      prod    = oct * frm;
      quarter = prod[13:`LC_OCT_SHIFT];
      if (cfg_active.coding_8b10b) begin
         period_m1 = (quarter == 12'h000) ? 12'h000 : quarter - 12'h001;
      end else begin
         period_m1 = {2'b00, cfg_active.mb_m1, `LC_BLOCKS_M1};
      end
      wrap = (lmfc == period_m1);
   end

   // Alignment sequencing per subclass and role
   always_comb begin
      next_state  = state;
      next_lmfc   = wrap ? 12'h000 : lmfc + 12'h001;
      next_sync_n = sync_n_out;
      next_err    = align_err;
      unique case (state)
         // Restart lands here for one cycle
         link_cfg_pkg::LINK_IDLE: begin
            next_lmfc   = 12'h000;
            next_sync_n = 1'b0;
            next_state  = link_cfg_pkg::LINK_WAIT;
         end
         // Waiting for the alignment event of the subclass
         link_cfg_pkg::LINK_WAIT: begin
            if (cfg_active.subclass == `LC_SUBCLASS_0) begin
               next_state  = link_cfg_pkg::LINK_RUN;
               next_sync_n = 1'b1;
            end else if (cfg_active.subclass == `LC_SUBCLASS_1) begin
               if (sysref_edge) begin
                  next_lmfc   = 12'h000;
                  next_state  = link_cfg_pkg::LINK_RUN;
                  next_sync_n = 1'b1;
               end
            end else if (rx_role) begin
               if (wrap) begin
                  next_state  = link_cfg_pkg::LINK_RUN;
                  next_sync_n = 1'b1;
               end
            end else begin
               if (sync_edge) begin
                  next_lmfc   = 12'h000;
                  next_state  = link_cfg_pkg::LINK_RUN;
                  next_sync_n = 1'b1;
               end
            end
         end
         // Running; later SYSREF edges may check the phase
         link_cfg_pkg::LINK_RUN: begin
            if (sysref_edge && cfg_active.sysref_all && !wrap) begin
               next_lmfc = 12'h000;
               next_err  = 1'b1;
            end
         end
      endcase
      // Core restart overrides all sequencing
      if (core_reset) begin
         next_state  = link_cfg_pkg::LINK_IDLE;
         next_lmfc   = 12'h000;
         next_sync_n = 1'b0;
         next_err    = 1'b0;
      end
      next_up  = (next_state == link_cfg_pkg::LINK_RUN);
      next_sof = (next_state == link_cfg_pkg::LINK_RUN) && (next_lmfc == period_m1);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= link_cfg_pkg::LINK_IDLE;
         lmfc       <= 12'h000;
         sync_n_out <= 1'b0;
         align_err  <= 1'b0;
         link_up    <= 1'b0;
         m_sof      <= 1'b0;
      end else begin
         state      <= next_state;
         lmfc       <= next_lmfc;
         sync_n_out <= next_sync_n;
         align_err  <= next_err;
         link_up    <= next_up;
         m_sof      <= next_sof;
      end
   end

   // ------------------------------------------------------------
   // Data stream on the core clock
   // ------------------------------------------------------------
   logic [63:0] next_tdata;    // Next stream word
   logic        next_tvalid;   // Next stream valid

   // Stream passes only while the link runs; upper half unused in 8B10B
   always_comb begin
      next_tvalid = s_tvalid && (state == link_cfg_pkg::LINK_RUN) && !core_reset;
      next_tdata  = s_tdata;
      if (cfg_active.coding_8b10b) begin
         next_tdata[63:32] = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         m_tdata  <= 64'h0000_0000_0000_0000;
         m_tvalid <= 1'b0;
      end else begin
         m_tdata  <= next_tdata;
         m_tvalid <= next_tvalid;
      end
   end

   // ------------------------------------------------------------
   // Received alignment content store
   // ------------------------------------------------------------
   // per lane readable store
   ila_store u_ila_store (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .restart   (core_reset),
      .cap_valid (ila_rx_valid),
      .cap_data  (ila_rx_data),
      .rd_lane   (ila_rd_lane),
      .rd_data   (ila_rd_data),
      .seen      (ila_seen)
   );

endmodule // serial_link_subclass_config

/* File: sim/link_cfg_asserts.sv */
// Port-level checks on the link configuration block.
// Assumes a bind onto serial_link_subclass_config, one core_clk domain.
`timescale 1ns/1ps
module link_cfg_asserts (
   // Clock and reset
   input wire logic               core_clk,
   input wire logic               reset_n,
   // Control and configuration
   input wire logic               core_reset,
   input wire logic               cfg_wr,
   input wire link_cfg_pkg::cfg_s cfg_wdata,
   input wire link_cfg_pkg::cfg_s cfg_prog,
   input wire link_cfg_pkg::cfg_s cfg_active,
   input wire logic               cfg_reject,
   // Timing and status
   input wire logic               sysref,
   input wire logic               sync_n_out,
   input wire logic               link_up,
   input wire logic [6:0]         dp_bits,
   input wire logic [6:0]         clk_ratio,
   // Streams
   input wire logic [63:0]        s_tdata,
   input wire logic               s_tvalid,
   input wire logic [63:0]        m_tdata,
   input wire logic               m_tvalid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Restart into subclass 0 with no second restart
   sequence seq_sc0_start;
      core_reset ##1 (!core_reset && cfg_active.subclass == 3'h0) ##1 !core_reset;
   endsequence
   AST_REJ_HIGH: assert property (cfg_wr && cfg_wdata.subclass > 3'h2 |=> cfg_reject)
      else $error("subclass above two not refused");
   AST_REJ_SC2: assert property (cfg_wr && !cfg_wdata.coding_8b10b
      && cfg_wdata.subclass == 3'h2 |=> cfg_reject && $stable(cfg_prog))
      else $error("subclass two with 64B66B not refused");
   AST_HOLD: assert property (!core_reset |=> $stable(cfg_active))
      else $error("active settings changed without restart");
   AST_APPLY: assert property (core_reset |=> cfg_active == $past(cfg_prog))
      else $error("restart did not apply programmed settings");
   AST_KEEP: assert property (core_reset && !cfg_wr |=> $stable(cfg_prog))
      else $error("restart disturbed programmed settings");
   AST_DP64: assert property (!cfg_active.coding_8b10b
      |-> dp_bits == 7'h40 && clk_ratio == 7'h42) else $error("64B66B width or ratio wrong");
   AST_DP32: assert property (cfg_active.coding_8b10b
      |-> dp_bits == 7'h20 && clk_ratio == 7'h28) else $error("8B10B width or ratio wrong");
   AST_SC0_UP: assert property (seq_sc0_start |=> link_up)
      else $error("subclass 0 link not up on time");
   AST_SC1_EDGE: assert property ($rose(link_up) && cfg_active.subclass == 3'h1
      |-> $past(sysref, 2) && !$past(sysref, 3)) else $error("subclass 1 up without SYSREF");
   AST_SYNC: assert property ($rose(sync_n_out) |-> $rose(link_up))
      else $error("SYNC released apart from link up");
   AST_STREAM: assert property (!core_reset |=> m_tvalid == $past(s_tvalid && link_up)
      && (!m_tvalid || m_tdata[31:0] == $past(s_tdata[31:0]))) else $error("stream mismatch");
endmodule // link_cfg_asserts

bind serial_link_subclass_config link_cfg_asserts link_cfg_asserts_i (.core_clk, .reset_n,
   .core_reset, .cfg_wr, .cfg_wdata, .cfg_prog, .cfg_active, .cfg_reject, .sysref,
   .sync_n_out, .link_up, .dp_bits, .clk_ratio, .s_tdata, .s_tvalid, .m_tdata, .m_tvalid);

/* File: sim/converter_model.sv */
// Converter side model: SYSREF patterns and a SYNC launch.
// Assumes core_clk is shared with the block under test.
`timescale 1ns/1ps
module converter_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // Pattern: 0 none, 1 one-shot, 2 periodic, 3 gapped periodic
   input  wire logic [1:0] mode,
   // Timing outputs
   output logic            sysref,
   output logic            sync_n_in
);
   logic [4:0] cnt;  // Period counter
   logic       shot; // One-shot already sent
   logic       gap;  // Gapped phase skips a period
   // SYNC low in mode 0, released after SYSREF
   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         {cnt, shot, gap, sysref, sync_n_in} <= '0;
      end else begin
         cnt <= cnt + 5'h01;
         gap <= gap ^ (cnt == 5'h1f);
         shot <= shot | (mode == 2'h1 && sysref);
         sysref <= (cnt == 5'h00 || (cnt == 5'h01 && sysref)) && (mode == 2'h2
                   || (mode == 2'h3 && !gap) || (mode == 2'h1 && !shot));
         sync_n_in <= (mode != 2'h0) && (sync_n_in | sysref);
      end
   end
endmodule // converter_model

/* File: sim/testbench.sv */
// Self-checking bench for the link configuration block.
// Assumes design sources, checker and converter model compiled first.
`timescale 1ns/1ps
module testbench;
   logic core_clk, reset_n, core_reset, cfg_wr, rx_role, s_tvalid, sysref, sync_n_in;
   logic sync_n_out, link_up, align_err, rate_ok, cfg_reject, m_tvalid, m_sof;
   logic [6:0]  dp_bits, clk_ratio;
   logic [7:0]  ila_rx_valid, ila_seen;
   logic [2:0]  ila_rd_lane;
   logic [1:0]  mode;
   logic [63:0] s_tdata, m_tdata;
   link_cfg_pkg::cfg_s cfg_wdata, cfg_prog, cfg_active;
   link_cfg_pkg::ila_s ila_tx_cfg, ila_rx_data, ila_rd_data;
   int num_errors, compares;
   serial_link_subclass_config serial_link_subclass_config_i (.core_clk, .reset_n,
      .core_reset, .cfg_wr, .cfg_wdata, .cfg_prog, .cfg_active, .cfg_reject, .rx_role,
      .sysref, .sync_n_in, .sync_n_out, .link_up, .align_err, .dp_bits, .clk_ratio,
      .rate_ok, .ila_tx_cfg, .ila_rx_valid, .ila_rx_data, .ila_rd_lane, .ila_rd_data,
      .ila_seen, .s_tdata, .s_tvalid, .m_tdata, .m_tvalid, .m_sof);
   converter_model converter_model_i (.core_clk, .reset_n, .mode, .sysref, .sync_n_in);
   // 50 MHz clock
   always #10 core_clk = ~core_clk;
   // Compare and count
   task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Step past edges, then settle
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Counts and verdict
   task automatic wrap_up;
      $display("compares=%0d errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Bounded wait for link up
   task automatic wait_up;
      for (int n = 0; link_up !== 1'b1; n++) begin
         if (n > 300) begin
            num_errors++;
            wrap_up;
         end
         cyc(1);
      end
   endtask
   // Write one setting, optionally restart
   task automatic prog(input logic code, input logic [2:0] sub, input logic rst);
      cfg_wdata = '0;
      cfg_wdata.coding_8b10b = code;
      cfg_wdata.subclass = sub;
      cfg_wdata.frames_m1 = 5'h1f;
      cfg_wdata.rate_mbps = 16'h3e80;
      cfg_wdata.sysref_all = 1'b1;
      cfg_wr = 1'b1;
      cyc(1);
      cfg_wr = 1'b0;
      core_reset = rst;
      cyc(1);
      core_reset = 1'b0;
   endtask
   // Scenarios, each judging its own results
   task automatic sc_defaults;
      check_val(64'(cfg_prog.subclass), 64'h1);
      check_val(64'({dp_bits, clk_ratio}), 64'h2042);
      prog(1'b0, 3'h2, 1'b0);
      check_val(64'(cfg_prog.subclass), 64'h1);
      prog(1'b1, 3'h3, 1'b0);
      check_val(64'(cfg_prog.subclass), 64'h1);
      $display("defaults done");
   endtask
   task automatic sc_class0;
      mode = 2'h2;
      prog(1'b1, 3'h0, 1'b0);
      check_val(64'(cfg_active.subclass), 64'h1);
      prog(1'b1, 3'h0, 1'b1);
      check_val(64'({cfg_prog.subclass, dp_bits, clk_ratio, rate_ok}), 64'h2051);
      check_val(64'(ila_tx_cfg), 64'h1f00);
      wait_up;
      s_tdata = 64'hdead_beef_0123_4567;
      s_tvalid = 1'b1;
      cyc(1);
      s_tvalid = 1'b0;
      check_val({m_tvalid, m_tdata[62:0]}, 64'h8000_0000_0123_4567);
      cyc(5);
      check_val(64'(m_sof), 64'h1);
      $display("subclass 0 done");
   endtask
   task automatic sc_class1;
      mode = 2'h0;
      prog(1'b0, 3'h1, 1'b1);
      cyc(40);
      check_val(64'(link_up), 64'h0);
      mode = 2'h1;
      wait_up;
      mode = 2'h3;
      cyc(100);
      check_val(64'({align_err, link_up, dp_bits}), 64'hc0);
      $display("subclass 1 done");
   endtask
   task automatic sc_class2;
      mode = 2'h0;
      rx_role = 1'b1;
      prog(1'b1, 3'h2, 1'b1);
      wait_up;
      check_val(64'(sync_n_out), 64'h1);
      rx_role = 1'b0;
      prog(1'b1, 3'h2, 1'b1);
      cyc(20);
      check_val(64'(link_up), 64'h0);
      mode = 2'h2;
      wait_up;
      $display("subclass 2 done");
   endtask
   task automatic sc_capture;
      ila_rx_data.octets_m1 = 8'h07;
      ila_rx_data.lane_id = 5'h03;
      ila_rx_valid = 8'h08;
      cyc(1);
      ila_rx_valid = 8'h00;
      ila_rd_lane = 3'h3;
      cyc(2);
      check_val(64'({ila_seen, ila_rd_data}), 64'h4000_c007);
      $display("capture done");
   endtask
   initial begin
      {core_clk, reset_n, core_reset, cfg_wr, rx_role, s_tvalid} = '0;
      {ila_rx_valid, ila_rd_lane, mode, s_tdata, num_errors, compares} = '0;
      cfg_wdata = '0;
      ila_rx_data = '0;
      cyc(16);
      reset_n = 1'b1;
      cyc(2);
      sc_defaults;
      sc_class0;
      sc_class1;
      sc_class2;
      sc_capture;
      wrap_up;
   end
endmodule // testbench
